//--- logic/acq_ctrl.sv
/*
 Acquisition control: start/stop gating, trigger sourcing and filtering,
 exposure and readout sequencing, with a classic Wishbone register slave.
 Assumes trigger pins are asynchronous and the bus master is on SYS_CLK.
*/
`timescale 1ns/1ps
module acq_ctrl
  import acq_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        LINK_TRIGGER_INPUT,
  input  wire logic        EXTERNAL_TRIGGER_LINE,
  output logic             ACQ_ENABLED,
  output logic             EXPOSURE_ACTIVE,
  output logic             READOUT_ACTIVE,
  output logic             FRAME_DONE
);

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [1:0] st_code(input state_t s);
    logic [1:0] c;
    c = 2'h0;
    case (s)
      ST_WAIT:   c = 2'h1;
      ST_EXPOSE: c = 2'h2;
      ST_READ:   c = 2'h3;
      default:   c = 2'h0;
    endcase
    return c;
  endfunction : st_code

  logic        ack_r;
  logic [31:0] rdat_r;
  ctrl_t       ctrl_r;
  logic [31:0] expose_r;
  logic [31:0] period_r;
  logic [31:0] readout_r;
  logic        acq_en_r;
  logic        stop_pend_r;
  state_t      state_r;
  logic [31:0] exp_cnt_r;
  logic [31:0] rd_cnt_r;
  logic        timed_r;
  logic [31:0] per_cnt_r;
  logic [15:0] frame_cnt_r;
  logic        link_s1_r;
  logic        link_s2_r;
  logic        link_d_r;
  logic        ext_s1_r;
  logic        ext_s2_r;
  logic        ext_f_r;
  logic        ext_fd_r;
  logic [7:0]  filt_cnt_r;
  logic        done_r;

  logic        req;
  logic        wr_en;
  logic        cmd_wr;
  logic        start_cmd;
  logic        stop_cmd;
  logic        busy;
  logic        lvl;
  logic        prev;
  logic        act_edge;
  logic        end_edge;
  logic        sw_trig;
  logic        hw_trig;
  logic        int_trig;
  logic        trig;
  logic        accept;
  logic [31:0] min_period;
  logic [31:0] eff_period;

  // Writes land on the edge where the master sees ack
  assign req       = WB_CYC_I & WB_STB_I;
  assign wr_en     = req & WB_WE_I & ack_r;
  assign cmd_wr    = wr_en & (WB_ADR_I == ADDR_CMD) & WB_SEL_I[0];
  assign start_cmd = cmd_wr & WB_DAT_I[CMD_START];
  assign stop_cmd  = cmd_wr & WB_DAT_I[CMD_STOP];
  assign busy      = (state_r == ST_EXPOSE) | (state_r == ST_READ);

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r) begin
        if (WB_ADR_I == ADDR_CTRL) begin
          rdat_r <= {27'h0000000, ctrl_r};
        end else if (WB_ADR_I == ADDR_EXPOSE) begin
          rdat_r <= expose_r;
        end else if (WB_ADR_I == ADDR_PERIOD) begin
          rdat_r <= period_r;
        end else if (WB_ADR_I == ADDR_READOUT) begin
          rdat_r <= readout_r;
        end else if (WB_ADR_I == ADDR_STATUS) begin
          rdat_r <= {frame_cnt_r, 12'h000, st_code(state_r), stop_pend_r, acq_en_r};
        end else begin
          rdat_r <= 32'h0000_0000;
        end
      end else begin
        // Zero outside ack, so stale read data never reaches the pins
        rdat_r <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r    <= CTRL_RST;
      expose_r  <= EXPOSE_RST;
      period_r  <= PERIOD_RST;
      readout_r <= READOUT_RST;
    end else if (wr_en) begin
      if (WB_ADR_I == ADDR_CTRL) begin
        if (WB_SEL_I[0]) begin
          ctrl_r <= WB_DAT_I[4:0];
        end
      end else if (WB_ADR_I == ADDR_EXPOSE) begin
        expose_r <= merge(expose_r, WB_DAT_I, WB_SEL_I);
      end else if (WB_ADR_I == ADDR_PERIOD) begin
        period_r <= merge(period_r, WB_DAT_I, WB_SEL_I);
      end else if (WB_ADR_I == ADDR_READOUT) begin
        readout_r <= merge(readout_r, WB_DAT_I, WB_SEL_I);
      end
    end
  end

  // Trigger pins are asynchronous; logic reads the second stage and the link delay copy, never the first
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      link_s1_r <= 1'b0;
      link_s2_r <= 1'b0;
      link_d_r  <= 1'b0;
      ext_s1_r  <= 1'b0;
      ext_s2_r  <= 1'b0;
    end else begin
      link_s1_r <= LINK_TRIGGER_INPUT;
      link_s2_r <= link_s1_r;
      link_d_r  <= link_s2_r;
      ext_s1_r  <= EXTERNAL_TRIGGER_LINE;
      ext_s2_r  <= ext_s1_r;
    end
  end

  // Level must hold a full microsecond before the filtered copy follows
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_f_r    <= 1'b0;
      ext_fd_r   <= 1'b0;
      filt_cnt_r <= 8'h00;
    end else begin
      ext_fd_r <= ext_f_r;
      if (ext_s2_r == ext_f_r) begin
        filt_cnt_r <= 8'h00;
      end else if (filt_cnt_r == 8'(FILT_CYC - 1)) begin
        ext_f_r    <= ext_s2_r;
        filt_cnt_r <= 8'h00;
      end else begin
        filt_cnt_r <= filt_cnt_r + 8'h01;
      end
    end
  end

  assign lvl      = (ctrl_r.src == SRC_LINK) ? link_s2_r : ext_f_r;
  assign prev     = (ctrl_r.src == SRC_LINK) ? link_d_r : ext_fd_r;
  assign act_edge = ctrl_r.act_fall ? (prev & ~lvl) : (~prev & lvl);
  assign end_edge = ctrl_r.act_fall ? (~prev & lvl) : (prev & ~lvl);

  // Exposure plus readout of one frame bounds how fast frames can follow
  assign min_period = expose_r + readout_r + 32'h0000_0002;
  assign eff_period = (period_r < min_period) ? min_period : period_r;

  assign sw_trig  = ctrl_r.trig_on & (ctrl_r.src == SRC_SW) & cmd_wr
                    & WB_DAT_I[CMD_SWTRIG];
  assign hw_trig  = ctrl_r.trig_on & ((ctrl_r.src == SRC_LINK) | (ctrl_r.src == SRC_EXT))
                    & act_edge;
  assign int_trig = ~ctrl_r.trig_on & acq_en_r & (per_cnt_r >= eff_period - 32'h1);
  assign trig     = sw_trig | hw_trig | int_trig;
  assign accept   = trig & (state_r == ST_WAIT) & ~stop_cmd;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      per_cnt_r <= 32'h0000_0000;
    end else if (start_cmd | (int_trig & accept) | ~acq_en_r) begin
      per_cnt_r <= 32'h0000_0000;
    end else if (per_cnt_r != 32'hffff_ffff) begin
      per_cnt_r <= per_cnt_r + 32'h1;
    end
  end

  // Acquisition enable; stop is deferred while a frame is under way
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acq_en_r    <= 1'b0;
      stop_pend_r <= 1'b0;
    end else if (stop_cmd & ~busy) begin
      acq_en_r    <= 1'b0;
      stop_pend_r <= 1'b0;
    end else if (stop_cmd) begin
      stop_pend_r <= 1'b1;
    end else if (start_cmd) begin
      acq_en_r    <= 1'b1;
      stop_pend_r <= 1'b0;
    end else if (stop_pend_r & ~busy) begin
      acq_en_r    <= 1'b0;
      stop_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r     <= ST_IDLE;
      exp_cnt_r   <= 32'h0000_0000;
      rd_cnt_r    <= 32'h0000_0000;
      timed_r     <= 1'b1;
      frame_cnt_r <= 16'h0000;
      done_r      <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start_cmd & ~stop_cmd) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (stop_cmd | stop_pend_r | ~acq_en_r) begin
            state_r <= ST_IDLE;
          end else if (accept) begin
            state_r   <= ST_EXPOSE;
            exp_cnt_r <= (expose_r == 32'h0) ? 32'h1 : expose_r;
            // Software and internal triggers have no width to measure
            timed_r   <= ~ctrl_r.exp_width | ~ctrl_r.trig_on
                         | (ctrl_r.src == SRC_SW);
          end
        end
        ST_EXPOSE: begin
          if (timed_r) begin
            exp_cnt_r <= exp_cnt_r - 32'h1;
          end
          if ((timed_r & (exp_cnt_r == 32'h1)) | (~timed_r & end_edge)) begin
            state_r  <= ST_READ;
            rd_cnt_r <= (readout_r == 32'h0) ? 32'h1 : readout_r;
          end
        end
        ST_READ: begin
          rd_cnt_r <= rd_cnt_r - 32'h1;
          if (rd_cnt_r == 32'h1) begin
            done_r      <= 1'b1;
            frame_cnt_r <= frame_cnt_r + 16'h1;
            state_r     <= (stop_pend_r | stop_cmd) ? ST_IDLE : ST_WAIT;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK_O        <= 1'b0;
      ACQ_ENABLED     <= 1'b0;
      EXPOSURE_ACTIVE <= 1'b0;
      READOUT_ACTIVE  <= 1'b0;
      FRAME_DONE      <= 1'b0;
    end else begin
      WB_ACK_O        <= req & ~ack_r;
      ACQ_ENABLED     <= acq_en_r;
      EXPOSURE_ACTIVE <= (state_r == ST_EXPOSE);
      READOUT_ACTIVE  <= (state_r == ST_READ);
      FRAME_DONE      <= done_r;
    end
  end

  // Read data is loaded on the same edge that raises ack
  assign WB_DAT_O = rdat_r;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  property p_no_frame_wo_en;
    $rose(state_r == ST_EXPOSE) |-> $past(acq_en_r);
  endproperty
  a_no_frame_wo_en: assert property (p_no_frame_wo_en)
    else $error("exposure began without acquisition enabled");

  property p_accept;
    (state_r == ST_WAIT && acq_en_r && !stop_pend_r && trig && !stop_cmd)
      |=> (state_r == ST_EXPOSE) ##1 EXPOSURE_ACTIVE;
  endproperty
  a_accept: assert property (p_accept)
    else $error("accepted trigger did not start exposure");

  property p_discard;
    (state_r == ST_READ && trig && rd_cnt_r > 32'h1) |=> (state_r == ST_READ);
  endproperty
  a_discard: assert property (p_discard)
    else $error("trigger during readout was not ignored");

  property p_stop_idle;
    (stop_cmd && !busy) |=> !acq_en_r && (state_r == ST_IDLE) ##1 !ACQ_ENABLED;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("idle stop did not disable at once");

  property p_stop_busy;
    (stop_cmd && busy && acq_en_r) |=> acq_en_r && stop_pend_r;
  endproperty
  a_stop_busy: assert property (p_stop_busy)
    else $error("stop during frame cut the frame short");

  property p_filter;
    $changed(ext_f_r) |-> $past(filt_cnt_r) == 8'(FILT_CYC - 1)
                          && $past(ext_s2_r) == ext_f_r;
  endproperty
  a_filter: assert property (p_filter)
    else $error("trigger line filter changed early");

  property p_timed_end;
    (state_r == ST_EXPOSE && timed_r && exp_cnt_r == 32'h1)
      |=> (state_r == ST_READ) ##1 (READOUT_ACTIVE && !EXPOSURE_ACTIVE);
  endproperty
  a_timed_end: assert property (p_timed_end)
    else $error("timed exposure did not end on count");

  property p_width_end;
    (state_r == ST_EXPOSE && !timed_r)
      |-> if (end_edge) ##1 (state_r == ST_READ)
          else ##1 (state_r == ST_EXPOSE);
  endproperty
  a_width_end: assert property (p_width_end)
    else $error("pulse-width exposure not ended by opposite edge");

  property p_frame_done;
    (state_r == ST_READ && rd_cnt_r == 32'h1) |=> done_r ##1 FRAME_DONE;
  endproperty
  a_frame_done: assert property (p_frame_done)
    else $error("finished readout gave no frame pulse");

  property p_int_rate;
    (int_trig && accept)
      |-> (per_cnt_r + 32'h1 >= period_r)
          && (per_cnt_r + 32'h1 >= expose_r + readout_r + 32'h2);
  endproperty
  a_int_rate: assert property (p_int_rate)
    else $error("internal trigger faster than allowed");

endmodule : acq_ctrl

//--- logic/acq_pkg.sv
/*
 Constants, register map and carrier types for the acquisition control block.
 Assumes a 50 MHz system clock and a 32-bit classic Wishbone register bus.
*/
// What this block does
// - No frame is acquired until a start command since reset or last stop.
// - Only continuous mode: one start keeps acquisition enabled for any frame count.
// - Enabled state persists until stop; after stop no frames until next start.
// - Stop while no frame in progress disables acquisition at once.
// - Stop during a frame finishes that frame, then disables acquisition.
// - Trigger accepted while waiting starts exposure then readout of one frame.
// - Block returns to waiting as soon as it can accept another trigger.
// - With triggering off, the block makes every trigger itself.
// - Internal trigger rate comes from the frame period setting.
// - With triggering on, one exposure per trigger from the selected source.
// - Triggers arriving outside the waiting state are dropped, never queued.
// - Software source: each software trigger command gives one trigger.
// - Link source: each valid link trigger event gives one trigger.
// - External source: each valid pulse on the trigger line gives one trigger.
// - Software source always uses timed exposure of the programmed time.
// - Link or external source offers timed and pulse-width exposure modes.
// - Pulse-width mode takes exposure length from the trigger edges per frame.
// - Each accepted trigger while enabled acquires and sends one frame.
// - Link or external source triggers on rising or falling edge as configured.
// - External line pulses narrower than 1 us are ignored.
// - Internal triggering starts on start command and runs until stop.
// - Requested internal rate above maximum is clamped to the maximum rate.
package acq_pkg;
  localparam int          CLK_MHZ      = 50;
  localparam int          MIN_PULSE_NS = 1000;
  localparam int          FILT_CYC     = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;

  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_CMD     = 8'h04;
  localparam logic [7:0]  ADDR_EXPOSE  = 8'h08;
  localparam logic [7:0]  ADDR_PERIOD  = 8'h0c;
  localparam logic [7:0]  ADDR_READOUT = 8'h10;
  localparam logic [7:0]  ADDR_STATUS  = 8'h14;

  localparam int          CMD_START    = 0;
  localparam int          CMD_STOP     = 1;
  localparam int          CMD_SWTRIG   = 2;

  localparam logic [1:0]  SRC_SW       = 2'h0;
  localparam logic [1:0]  SRC_LINK     = 2'h1;
  localparam logic [1:0]  SRC_EXT      = 2'h2;

  localparam logic [31:0] EXPOSE_RST   = 32'h0000_c350;
  localparam logic [31:0] PERIOD_RST   = 32'h000f_4240;
  localparam logic [31:0] READOUT_RST  = 32'h0000_2710;
  localparam logic [4:0]  CTRL_RST     = 5'h00;

  typedef struct packed {
    logic       exp_width;
    logic       act_fall;
    logic [1:0] src;
    logic       trig_on;
  } ctrl_t;

  typedef enum {ST_IDLE, ST_WAIT, ST_EXPOSE, ST_READ} state_t;
endpackage : acq_pkg

//--- tb/image_acquisition_control_test.sv
/*
 Self-checking bench for acq_ctrl: register reset values, start/stop gating,
 trigger sources and exposure timing. Assumes acq_pkg and trig_source.
*/
`timescale 1ns/1ps
module image_acquisition_control_test
  import acq_pkg::*;
;
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] val;
  } row_t;

  logic        SYS_CLK, RST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic [7:0]  WB_ADR_I;
  logic [3:0]  WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, q;
  logic        LINK_TRIGGER_INPUT, EXTERNAL_TRIGGER_LINE;
  logic        ACQ_ENABLED, EXPOSURE_ACTIVE, READOUT_ACTIVE, FRAME_DONE;
  logic        exp_d, rd_d;
  int          failures, samples_checked, cyc, frames, exp_run, rd_run, gap, last_rise, f0;
  row_t        rows [7];

  acq_ctrl u_acq_ctrl (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .LINK_TRIGGER_INPUT(LINK_TRIGGER_INPUT), .EXTERNAL_TRIGGER_LINE(EXTERNAL_TRIGGER_LINE),
    .ACQ_ENABLED(ACQ_ENABLED), .EXPOSURE_ACTIVE(EXPOSURE_ACTIVE),
    .READOUT_ACTIVE(READOUT_ACTIVE), .FRAME_DONE(FRAME_DONE));

  trig_source u_trig_source (.clk(SYS_CLK), .link_line(LINK_TRIGGER_INPUT),
    .ext_line(EXTERNAL_TRIGGER_LINE));

  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end

  task end_of_test;
    if (failures == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask : tick

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge SYS_CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= w;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    WB_SEL_I <= 4'hf;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 50);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    if (n >= 50) begin
      failures++;
      end_of_test;
    end
  endtask : wb

  task cmd(input int b);
    wb(1'b1, ADDR_CMD, 32'h1 << b);
  endtask : cmd

  function automatic logic [31:0] ctl(input logic pw, input logic fall,
                                      input logic [1:0] s, input logic on);
    ctrl_t c;
    c.exp_width = pw;
    c.act_fall  = fall;
    c.src       = s;
    c.trig_on   = on;
    return {27'h0, c};
  endfunction : ctl

  always @(posedge SYS_CLK) begin
    cyc   <= cyc + 1;
    exp_d <= EXPOSURE_ACTIVE;
    rd_d  <= READOUT_ACTIVE;
    if (FRAME_DONE === 1'b1) frames <= frames + 1;
    if (EXPOSURE_ACTIVE === 1'b1) exp_run <= (exp_d === 1'b1) ? exp_run + 1 : 1;
    if (READOUT_ACTIVE === 1'b1) rd_run <= (rd_d === 1'b1) ? rd_run + 1 : 1;
    if (EXPOSURE_ACTIVE === 1'b1 && exp_d !== 1'b1) begin
      gap       <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (cyc == 8000) begin
      failures++;
      end_of_test;
    end
  end

  initial begin
    {RST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} = '0;
    {failures, samples_checked, cyc, frames, exp_run, rd_run, gap, last_rise} = '0;
    rows = '{'{ADDR_CTRL, 32'h0}, '{ADDR_EXPOSE, EXPOSE_RST}, '{ADDR_PERIOD, PERIOD_RST},
             '{ADDR_READOUT, READOUT_RST}, '{ADDR_STATUS, 32'h0}, '{ADDR_CMD, 32'h0},
             '{8'h20, 32'h0}};
    tick(12);
    chk({28'h0, ACQ_ENABLED, EXPOSURE_ACTIVE, READOUT_ACTIVE, FRAME_DONE}, 32'h0);
    chk({31'h0, WB_ACK_O}, 32'h0);
    chk(WB_DAT_O, 32'h0);
    RST_N <= 1'b1;
    foreach (rows[i]) begin
      wb(1'b0, rows[i].adr, 32'h0);
      chk(q, rows[i].val);
    end
    wb(1'b1, ADDR_EXPOSE, 32'h4);
    wb(1'b0, ADDR_EXPOSE, 32'h0);
    chk(q, 32'h4);
    wb(1'b1, ADDR_READOUT, 32'h3);
    wb(1'b1, ADDR_PERIOD, 32'h14);
    wb(1'b1, ADDR_CTRL, ctl(1'b0, 1'b0, SRC_SW, 1'b1));
    cmd(CMD_SWTRIG);
    tick(20);
    chk(frames, 0);
    cmd(CMD_START);
    tick(3);
    chk({31'h0, ACQ_ENABLED}, 32'h1);
    cmd(CMD_SWTRIG);
    cmd(CMD_SWTRIG);
    cmd(CMD_SWTRIG);
    tick(30);
    chk(frames, 1);
    chk(exp_run, 4);
    chk(rd_run, 3);
    cmd(CMD_SWTRIG);
    tick(30);
    chk(frames, 2);
    cmd(CMD_SWTRIG);
    cmd(CMD_STOP);
    tick(30);
    chk(frames, 3);
    chk({31'h0, ACQ_ENABLED}, 32'h0);
    cmd(CMD_SWTRIG);
    tick(30);
    chk(frames, 3);
    cmd(CMD_START);
    tick(5);
    cmd(CMD_STOP);
    tick(3);
    chk({31'h0, ACQ_ENABLED}, 32'h0);
    wb(1'b1, ADDR_CTRL, 32'h0);
    cmd(CMD_START);
    tick(80);
    chk(gap, 20);
    wb(1'b1, ADDR_PERIOD, 32'h2);
    tick(60);
    chk(gap, 9);
    cmd(CMD_STOP);
    tick(30);
    f0 = frames;
    tick(40);
    chk(frames, f0);
    wb(1'b1, ADDR_CTRL, ctl(1'b0, 1'b1, SRC_LINK, 1'b1));
    cmd(CMD_START);
    u_trig_source.level(1'b0, 1'b1);
    tick(30);
    chk(frames, f0);
    u_trig_source.level(1'b0, 1'b0);
    tick(30);
    chk(frames, f0 + 1);
    wb(1'b1, ADDR_CTRL, ctl(1'b1, 1'b0, SRC_LINK, 1'b1));
    u_trig_source.pulse(1'b0, 1'b1, 40);
    tick(20);
    chk(exp_run, 40);
    u_trig_source.pulse(1'b0, 1'b1, 25);
    tick(20);
    chk(exp_run, 25);
    wb(1'b1, ADDR_CTRL, ctl(1'b0, 1'b0, SRC_EXT, 1'b1));
    f0 = frames;
    u_trig_source.pulse(1'b1, 1'b1, 30);
    tick(80);
    chk(frames, f0);
    u_trig_source.pulse(1'b1, 1'b1, 60);
    tick(40);
    chk(frames, f0 + 1);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk(q, {frames[15:0], 16'h0005});
    end_of_test;
  end
endmodule : image_acquisition_control_test

//--- tb/trig_source.sv
/*
 Far-side trigger model: drives the link and external trigger levels.
 Assumes the caller spaces its pulses no closer than one frame time.
*/
`timescale 1ns/1ps
module trig_source (
  input  wire logic clk,
  output logic      link_line,
  output logic      ext_line
);
  initial begin
    link_line = 1'b0;
    ext_line  = 1'b0;
  end

  // Steady level change; one edge only
  task automatic level(input logic ext, input logic v);
    @(posedge clk);
    if (ext) ext_line <= v;
    else link_line <= v;
  endtask : level

  // Pulse of w cycles, then back to the opposite level
  task automatic pulse(input logic ext, input logic v, input int w);
    level(ext, v);
    repeat (w) @(posedge clk);
    if (ext) ext_line <= ~v;
    else link_line <= ~v;
    repeat (w + 20) @(posedge clk);
  endtask : pulse
endmodule : trig_source
